// ===== hdl/dif_pkg.sv
// Constants shared by the instruction format and timing front end.
// Assumes a 24-bit instruction word stream and a 32-bit APB register bus.
package dif_pkg;

  localparam int WORD_W = 24;
  localparam int NFLAGS = 9;
  localparam int ADDR_W = 12;

  // Opcode values of the special instruction kinds
  localparam logic [7:0] OPC_NOP = 8'h00;
  localparam logic [7:0] OPC_IND_JUMP = 8'h01;
  localparam logic [7:0] OPC_CALL_LONG = 8'h02;
  localparam logic [7:0] OPC_JUMP_LONG = 8'h04;
  localparam logic [7:0] OPC_RETURN = 8'h06;
  localparam logic [7:0] OPC_INT_EXIT = 8'h07;
  localparam logic [7:0] OPC_LOOP_LONG = 8'h08;
  localparam logic [7:0] OPC_BRANCH = 8'h37;
  localparam logic [7:0] OPC_DMOV = 8'hF8;

  // Opcode groups, selected by the upper opcode nibble
  localparam logic [3:0] GRP_COND_BR = 4'h3;
  localparam logic [3:0] GRP_WORK_LO = 4'h4;
  localparam logic [3:0] GRP_WORK_HI = 4'h7;
  localparam logic [3:0] GRP_FILE = 4'h8;
  localparam logic [3:0] GRP_LIT = 4'h9;
  localparam logic [3:0] GRP_BIT = 4'hA;
  localparam logic [3:0] GRP_DSP = 4'hC;
  localparam logic [3:0] GRP_TABLE = 4'hD;
  localparam logic [3:0] GRP_SKIP = 4'hE;

  // Added no-operation cycles per kind
  localparam logic [1:0] XTRA_BRANCH = 2'h1;
  localparam logic [1:0] XTRA_TABLE = 2'h1;
  localparam logic [1:0] XTRA_RETURN = 2'h2;
  localparam logic [1:0] XTRA_DMOV = 2'h1;
  localparam logic [1:0] XTRA_COND = 2'h1;

  // Operand field positions inside a word
  localparam int F_OPC_LSB = 16;
  localparam int F_FILE_LSB = 0;
  localparam int F_DSEL = 15;
  localparam int F_BASE_LSB = 12;
  localparam int F_DMODE_LSB = 10;
  localparam int F_DREG_LSB = 6;
  localparam int F_SMODE_LSB = 4;
  localparam int F_SREG_LSB = 0;
  localparam int F_LIT_LSB = 4;
  localparam int F_LSIGN = 14;
  localparam int F_BIT_LSB = 12;
  localparam int F_ACC = 15;
  localparam int F_WB_TGT = 14;
  localparam int F_PAIR_LSB = 11;
  localparam int F_ADDR_LSB = 1;

  // Operand limits and constants
  localparam logic [9:0] ULIT_BYTE_MAX = 10'h0FF;
  localparam logic [1:0] WB_STEP = 2'h2;
  localparam logic [2:0] PAIR_LAST = 3'h5;

  // Flag bit positions
  localparam int FLG_C = 0;
  localparam int FLG_DIGIT_CARRY = 1;
  localparam int FLG_N = 2;
  localparam int FLG_OVERFLOW = 3;
  localparam int FLG_Z = 4;
  localparam int FLG_ACC_A_OVERFLOW = 5;
  localparam int FLG_ACC_B_OVERFLOW = 6;
  localparam int FLG_ACC_A_SATURATE = 7;
  localparam int FLG_ACC_B_SATURATE = 8;

  // Register byte offsets and reset values
  localparam logic [11:0] REG_CTRL = 12'h000;
  localparam logic [11:0] REG_FLAGS = 12'h004;
  localparam logic [11:0] REG_DECODE = 12'h008;
  localparam logic [11:0] REG_ERR = 12'h00C;
  localparam logic CTRL_RST = 1'b0;
  localparam logic [2:0] ERR_RST = 3'h0;
  localparam int ERR_SECOND = 0;
  localparam int ERR_PAIR = 1;
  localparam int ERR_LIT = 2;

  typedef enum logic [4:0] {
    ST_FETCH = 5'b00001,
    ST_SECOND = 5'b00010,
    ST_STALL = 5'b00100,
    ST_SKIP = 5'b01000,
    ST_SKIP2 = 5'b10000
  } dif_state_t;

endpackage

// ===== hdl/dif_operand_check.sv
// Operand legality checks: literal range and multiplier register pair.
// Assumes raw fields straight from the decode word; purely combinational.
`timescale 1ns/1ps
module dif_operand_check
  import dif_pkg::*;
(
  input wire logic [9:0] lit_raw,
  input wire logic byte_mode,
  input wire logic lit_signed,
  input wire logic [2:0] pair_code,
  output logic lit_ok,
  output logic pair_ok,
  output logic [3:0] mul_x,
  output logic [3:0] mul_y
);

  // Signed literals span -512..511 whatever the width mode
  assign lit_ok = lit_signed | ~byte_mode | (lit_raw <= ULIT_BYTE_MAX);

  // Only six pairs exist; codes 6 and 7 are refused
  assign pair_ok = (pair_code <= PAIR_LAST);
  assign mul_x = (pair_code < 3'h3) ? 4'h4 : (pair_code < 3'h5) ? 4'h5 : 4'h6;
  assign mul_y = (pair_code == 3'h0) ? 4'h5 :
                 ((pair_code == 3'h1) || (pair_code == 3'h3)) ? 4'h6 : 4'h7;

endmodule // dif_operand_check

// ===== hdl/dif_flag_bank.sv
// Status flag bank with per-bit write enables and a hold input.
// Assumes enables come from the execution unit on the same clock.
`timescale 1ns/1ps
module dif_flag_bank
  import dif_pkg::*;
#(
  parameter int N = NFLAGS
) (
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic hold,
  input wire logic [N-1:0] we,
  input wire logic [N-1:0] din,
  output logic [N-1:0] flags_q
);

  logic [N-1:0] flags_d;

  // Hold freezes every flag during inserted no-operation cycles
  assign flags_d = hold ? flags_q : ((flags_q & ~we) | (din & we));

  // Flags kept per bit as each instruction asks
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      flags_q <= '0;
    end else begin
      flags_q <= flags_d;
    end
  end

endmodule // dif_flag_bank

// ===== hdl/dif_decoder.sv
// Instruction format decoder and cycle sequencer with APB status registers.
// Assumes program memory offers one 24-bit word per accepted cycle and
// COND_TRUE is valid together with IWORD.
//
// Overview of operation
// - 24-bit words, 8-bit opcode then operand fields
// - exactly three opcodes occupy two words
// - two-word instruction is 48 bits, zero top byte
// - orphaned second word executes as no operation
// - one cycle; taken condition adds one idle cycle
// - branches, tables, returns take two or three cycles
// - taken skip costs two or three cycles
// - double moves and two-word instructions take two cycles
// - file instructions give address and file/W0 destination
// - W instructions give base, source, destination registers
// - file address spans zero through 0x1FFF
// - unsigned literal max 255 byte, 1023 word
// - program address literal is always even
// - write-back goes to W13 or [W13] post-increment 2
// - four-bit field selects bit 0 through 15
// - DSP operations select accumulator A or B
// - arithmetic and DSP status flags are kept
// - signed literal is two's complement -512..511
// - multiplier operands only from six register pairs
`timescale 1ns/1ps
module dif_decoder
  import dif_pkg::*;
(
  input wire logic CLK,
  input wire logic RESETN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [ADDR_W-1:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic IWORD_VALID,
  input wire logic [WORD_W-1:0] IWORD,
  input wire logic COND_TRUE,
  output logic IWORD_READY,
  output logic EXEC_VALID,
  output logic EXEC_NOP,
  output logic [7:0] OPCODE,
  output logic BYTE_MODE,
  output logic [12:0] FILE_ADDR,
  output logic DEST_IS_FILE,
  output logic [3:0] BASE_SOURCE_REG,
  output logic [3:0] SECOND_SOURCE_REG,
  output logic [1:0] SRC_MODE,
  output logic [3:0] DEST_REG,
  output logic [1:0] DST_MODE,
  output logic [9:0] UNSIGNED_TEN_BIT_LITERAL,
  output logic signed [9:0] SIGNED_TEN_BIT_LITERAL,
  output logic [3:0] BIT_POSITION_SELECT,
  output logic ACC_SEL,
  output logic ACCUMULATOR_WRITEBACK_TARGET,
  output logic [1:0] WB_POST_INC,
  output logic [3:0] MUL_X,
  output logic [3:0] MUL_Y,
  output logic [22:0] PROGRAM_ADDRESS_LITERAL,
  input wire logic [NFLAGS-1:0] FLAG_WE,
  input wire logic [NFLAGS-1:0] FLAG_IN,
  output logic [NFLAGS-1:0] STATUS_FLAGS
);

  ////////////////////////////////////////////////////////////////////////////
  // Word classification

  dif_state_t state_q, state_d;
  logic [WORD_W-1:0] first_q;
  logic [1:0] cnt_q, cnt_d;
  logic enable_q;
  logic [2:0] err_q, err_set;

  wire [7:0] opc = IWORD[F_OPC_LSB +: 8];
  wire [3:0] grp = opc[7:4];
  wire accept = IWORD_VALID & IWORD_READY;
  wire is_two = (opc == OPC_CALL_LONG) | (opc == OPC_JUMP_LONG) | (opc == OPC_LOOP_LONG);
  wire top_zero = (opc == 8'h00);
  wire in_fetch = (state_q == ST_FETCH);
  wire in_second = (state_q == ST_SECOND);
  wire in_skip = (state_q == ST_SKIP) | (state_q == ST_SKIP2);

  // Fields come from the held first word while a second word is taken
  wire [WORD_W-1:0] dw = in_second ? first_q : IWORD;
  wire [7:0] dopc = dw[F_OPC_LSB +: 8];
  wire [3:0] dgrp = dopc[7:4];
  wire dbyte = dopc[0];
  wire dsigned = dw[F_LSIGN];

  logic lit_ok, pair_ok;
  logic [3:0] mul_x, mul_y;

  dif_operand_check u_check (
    .lit_raw(dw[F_LIT_LSB +: 10]),
    .byte_mode(dbyte),
    .lit_signed(dsigned),
    .pair_code(dw[F_PAIR_LSB +: 3]),
    .lit_ok(lit_ok),
    .pair_ok(pair_ok),
    .mul_x(mul_x),
    .mul_y(mul_y)
  );

  // Out-of-range literals and unknown pairs are executed as no operation
  wire bad_lit = (dgrp == GRP_LIT) & ~lit_ok;
  wire bad_pair = (dgrp == GRP_DSP) & ~pair_ok;
  wire illegal = bad_lit | bad_pair;

  // Extra idle cycles for the single-word kinds
  wire [1:0] xtra =
    illegal ? 2'h0 :
    ((opc == OPC_BRANCH) || (opc == OPC_IND_JUMP)) ? XTRA_BRANCH :
    ((opc == OPC_RETURN) || (opc == OPC_INT_EXIT)) ? XTRA_RETURN :
    (grp == GRP_TABLE) ? XTRA_TABLE :
    (opc == OPC_DMOV) ? XTRA_DMOV :
    ((grp == GRP_COND_BR) && COND_TRUE) ? XTRA_COND : 2'h0;
  wire skip_go = (grp == GRP_SKIP) & COND_TRUE & ~illegal;

  // Fetch is open while enabled unless the core is burning an idle cycle
  assign IWORD_READY = enable_q & (state_q != ST_STALL);

  ////////////////////////////////////////////////////////////////////////////
  // Sequencer

  always_comb begin
    state_d = state_q;
    cnt_d = cnt_q;
    unique case (state_q)
      ST_FETCH: begin
        if (accept) begin
          if (is_two) begin
            state_d = ST_SECOND;
          end else if (skip_go) begin
            state_d = ST_SKIP;
          end else if (xtra != 2'h0) begin
            state_d = ST_STALL;
            cnt_d = xtra;
          end
        end
      end
      ST_SECOND: begin
        if (accept) begin
          state_d = ST_FETCH;
        end
      end
      ST_STALL: begin
        cnt_d = cnt_q - 2'h1;
        if (cnt_q == 2'h1) begin
          state_d = ST_FETCH;
        end
      end
      ST_SKIP: begin
        // A skipped two-word instruction costs one more discarded word
        if (accept) begin
          state_d = is_two ? ST_SKIP2 : ST_FETCH;
        end
      end
      ST_SKIP2: begin
        if (accept) begin
          state_d = ST_FETCH;
        end
      end
    endcase
  end

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      state_q <= ST_FETCH;
      cnt_q <= 2'h0;
      first_q <= '0;
    end else begin
      state_q <= state_d;
      cnt_q <= cnt_d;
      first_q <= (in_fetch & accept & is_two) ? IWORD : first_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Issue and operand outputs

  // A second word with a non-zero top byte is refused as a no operation
  wire second_bad = in_second & accept & ~top_zero;
  wire issue = accept & ((in_fetch & ~is_two) | in_second);
  wire issue_nop = (in_fetch & top_zero) | illegal | second_bad;
  wire valid_d = issue & ~issue_nop;
  wire nop_d = (issue & issue_nop) | (state_q == ST_STALL) | (accept & in_skip);

  wire [22:0] addr_d = in_second ? {IWORD[6:0], dw[15:F_ADDR_LSB], 1'b0} :
                                   {7'h00, dw[15:F_ADDR_LSB], 1'b0};

  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      EXEC_VALID <= 1'b0;
      EXEC_NOP <= 1'b0;
    end else begin
      EXEC_VALID <= valid_d;
      EXEC_NOP <= nop_d;
    end
  end

  // Operand fields follow the word only when it really executes
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      OPCODE <= 8'h00;
      BYTE_MODE <= 1'b0;
      FILE_ADDR <= 13'h0000;
      DEST_IS_FILE <= 1'b0;
      BASE_SOURCE_REG <= 4'h0;
      SECOND_SOURCE_REG <= 4'h0;
      SRC_MODE <= 2'h0;
      DEST_REG <= 4'h0;
      DST_MODE <= 2'h0;
      UNSIGNED_TEN_BIT_LITERAL <= 10'h000;
      SIGNED_TEN_BIT_LITERAL <= 10'h000;
      BIT_POSITION_SELECT <= 4'h0;
      ACC_SEL <= 1'b0;
      ACCUMULATOR_WRITEBACK_TARGET <= 1'b0;
      MUL_X <= 4'h4;
      MUL_Y <= 4'h5;
      PROGRAM_ADDRESS_LITERAL <= 23'h000000;
    end else if (valid_d) begin
      OPCODE <= dopc;
      BYTE_MODE <= dbyte;
      FILE_ADDR <= dw[F_FILE_LSB +: 13];
      DEST_IS_FILE <= dw[F_DSEL];
      BASE_SOURCE_REG <= dw[F_BASE_LSB +: 4];
      SECOND_SOURCE_REG <= dw[F_SREG_LSB +: 4];
      SRC_MODE <= dw[F_SMODE_LSB +: 2];
      DEST_REG <= (dgrp == GRP_LIT) ? dw[F_SREG_LSB +: 4] : dw[F_DREG_LSB +: 4];
      DST_MODE <= dw[F_DMODE_LSB +: 2];
      UNSIGNED_TEN_BIT_LITERAL <= dw[F_LIT_LSB +: 10];
      SIGNED_TEN_BIT_LITERAL <= dw[F_LIT_LSB +: 10];
      BIT_POSITION_SELECT <= dw[F_BIT_LSB +: 4];
      ACC_SEL <= dw[F_ACC];
      ACCUMULATOR_WRITEBACK_TARGET <= dw[F_WB_TGT];
      MUL_X <= mul_x;
      MUL_Y <= mul_y;
      PROGRAM_ADDRESS_LITERAL <= addr_d;
    end
  end

  // Post-increment applies only when write-back goes through memory
  assign WB_POST_INC = ACCUMULATOR_WRITEBACK_TARGET ? WB_STEP : 2'h0;

  // Flags move only in cycles that truly execute
  dif_flag_bank #(.N(NFLAGS)) u_flags (
    .CLK(CLK),
    .RESETN(RESETN),
    .hold(~EXEC_VALID),
    .we(FLAG_WE),
    .din(FLAG_IN),
    .flags_q(STATUS_FLAGS)
  );

  ////////////////////////////////////////////////////////////////////////////
  // APB slave

  logic [31:0] prdata_q;
  logic [10:0] last_q;

  wire setup = PSEL & ~PENABLE;
  wire access = PSEL & PENABLE;
  wire hit_ctrl = (PADDR == REG_CTRL);
  wire hit_flags = (PADDR == REG_FLAGS);
  wire hit_dec = (PADDR == REG_DECODE);
  wire hit_err = (PADDR == REG_ERR);
  wire mapped = hit_ctrl | hit_flags | hit_dec | hit_err;
  wire wr_ctrl = access & PWRITE & hit_ctrl;
  wire wr_err = access & PWRITE & hit_err;
  wire [31:0] rd_mux = hit_ctrl ? {31'h0, enable_q} :
                       hit_flags ? {23'h0, STATUS_FLAGS} :
                       hit_dec ? {21'h0, last_q} :
                       hit_err ? {29'h0, err_q} : 32'h0;

  assign PREADY = 1'b1;
  assign PSLVERR = access & ~mapped;
  assign PRDATA = prdata_q;
  assign err_set = {bad_lit & issue & in_fetch, bad_pair & issue & in_fetch, second_bad};

  // Read data is captured in the setup cycle so it leaves a flip-flop
  always_ff @(posedge CLK or negedge RESETN) begin
    if (!RESETN) begin
      prdata_q <= 32'h0;
      enable_q <= CTRL_RST;
      err_q <= ERR_RST;
      last_q <= 11'h000;
    end else begin
      prdata_q <= setup ? rd_mux : prdata_q;
      enable_q <= wr_ctrl ? PWDATA[0] : enable_q;
      // New errors win over a clear in the same cycle
      err_q <= (err_q & ~(wr_err ? PWDATA[2:0] : 3'h0)) | err_set;
      last_q <= valid_d ? {xtra, in_second, dopc} : last_q;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Assertions

  default clocking cb @(posedge CLK); endclocking
  default disable iff (!RESETN);

  sequence s_stall2;
    EXEC_VALID ##1 EXEC_NOP ##1 EXEC_NOP;
  endsequence

  property p_two_word;
    (in_fetch && accept && is_two) |=> (in_second && !EXEC_VALID && !EXEC_NOP);
  endproperty
  a_two_word: assert property (p_two_word) else $error("two-word start not held");

  property p_second_bad;
    (in_second && accept && !top_zero) |=> (EXEC_NOP && !EXEC_VALID && err_q[ERR_SECOND]);
  endproperty
  a_second_bad: assert property (p_second_bad) else $error("bad second word executed");

  property p_orphan;
    (in_fetch && accept && top_zero) |=> (EXEC_NOP && !EXEC_VALID);
  endproperty
  a_orphan: assert property (p_orphan) else $error("orphan word not a no-op");

  property p_cond;
    (in_fetch && accept && (grp == GRP_COND_BR) && COND_TRUE && !illegal)
      |=> (EXEC_VALID && !IWORD_READY) ##1 (EXEC_NOP && !EXEC_VALID && in_fetch);
  endproperty
  a_cond: assert property (p_cond) else $error("taken condition not two cycles");

  property p_return;
    (in_fetch && accept && (opc == OPC_RETURN)) |=> s_stall2 ##0 in_fetch;
  endproperty
  a_return: assert property (p_return) else $error("return not three cycles");

  property p_skip;
    (in_fetch && accept && skip_go) |=> (state_q == ST_SKIP) ##0 (!accept || is_two || (state_d == ST_FETCH));
  endproperty
  a_skip: assert property (p_skip) else $error("skip sequence wrong");

  property p_even;
    EXEC_VALID |-> (PROGRAM_ADDRESS_LITERAL[0] == 1'b0);
  endproperty
  a_even: assert property (p_even) else $error("odd program address");

  property p_lit;
    (EXEC_VALID && (OPCODE[7:4] == GRP_LIT) && BYTE_MODE && !$past(dsigned)) |-> (UNSIGNED_TEN_BIT_LITERAL <= 10'h0FF);
  endproperty
  a_lit: assert property (p_lit) else $error("byte literal over 255");

  property p_pair;
    (EXEC_VALID && (OPCODE[7:4] == GRP_DSP)) |-> (MUL_X >= 4'h4 && MUL_X < MUL_Y && MUL_Y <= 4'h7);
  endproperty
  a_pair: assert property (p_pair) else $error("illegal multiplier pair");

  property p_hold;
    EXEC_NOP |=> $stable(STATUS_FLAGS);
  endproperty
  a_hold: assert property (p_hold) else $error("flags moved in idle cycle");

endmodule // dif_decoder

// ===== dv/dif_prog_mem_model.sv
// Behavioural program memory that offers queued 24-bit words to the decoder.
// Assumes the bench pushes words by hierarchical task call between clock edges.
`timescale 1ns/1ps
module dif_prog_mem_model
  import dif_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire logic slow,
  input wire logic word_ready,
  output logic word_valid,
  output logic [WORD_W-1:0] word,
  output logic cond_true,
  output logic empty
);
  logic [WORD_W:0] fifo_q[$];
  logic taken;

  // Queue one word together with its condition result
  task automatic push(input logic [WORD_W-1:0] w, input logic c);
    fifo_q.push_back({c, w});
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Offer the head word and hold it until taken; slow mode leaves one gap after each take.
  // An idle bus shows inverted data so a stale word can never pass for a fresh one.
  always @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      word_valid <= 1'b0;
      word <= 24'h000000;
      cond_true <= 1'b0;
      empty <= 1'b1;
    end else begin
      taken = word_valid && word_ready;
      if (taken) begin
        void'(fifo_q.pop_front());
      end
      if (fifo_q.size() > 0 && !(slow && taken)) begin
        word_valid <= 1'b1;
        word <= fifo_q[0][WORD_W-1:0];
        cond_true <= fifo_q[0][WORD_W];
      end else begin
        word_valid <= 1'b0;
        word <= ~word;
        cond_true <= ~cond_true;
      end
      empty <= (fifo_q.size() == 0);
    end
  end
endmodule // dif_prog_mem_model

// ===== dv/test_dsc_instruction_format_timing.sv
// Self-checking bench for the instruction format and timing decoder.
// Assumes the program memory model feeds words and APB reaches the status registers.
`timescale 1ns/1ps
module test_dsc_instruction_format_timing
  import dif_pkg::*;
;
  logic CLK, RESETN, PSEL, PENABLE, PWRITE, PREADY, PSLVERR, IWORD_VALID, COND_TRUE, IWORD_READY;
  logic EXEC_VALID, EXEC_NOP, BYTE_MODE, DEST_IS_FILE, ACC_SEL, WB_TGT, slow, mem_empty;
  logic [ADDR_W-1:0] PADDR;
  logic [31:0] PWDATA, PRDATA;
  logic [WORD_W-1:0] IWORD;
  logic [7:0] OPCODE;
  logic [12:0] FILE_ADDR;
  logic [3:0] BASE_SRC, SEC_SRC, DEST_REG, BIT_SEL, MUL_X, MUL_Y;
  logic [1:0] SRC_MODE, DST_MODE, WB_POST_INC;
  logic [9:0] ULIT;
  logic signed [9:0] SLIT;
  logic [22:0] PA_LIT;
  logic [NFLAGS-1:0] FLAG_WE, FLAG_IN, STATUS_FLAGS, fl_good;
  int n_errors = 0;
  int n_compared = 0;
  int n_v = 0;
  int n_n = 0;

  dif_decoder dif_decoder_i (
    .CLK(CLK), .RESETN(RESETN), .PSEL(PSEL), .PENABLE(PENABLE), .PWRITE(PWRITE), .PADDR(PADDR),
    .PWDATA(PWDATA), .PRDATA(PRDATA), .PREADY(PREADY), .PSLVERR(PSLVERR), .IWORD_VALID(IWORD_VALID),
    .IWORD(IWORD), .COND_TRUE(COND_TRUE), .IWORD_READY(IWORD_READY), .EXEC_VALID(EXEC_VALID),
    .EXEC_NOP(EXEC_NOP), .OPCODE(OPCODE), .BYTE_MODE(BYTE_MODE), .FILE_ADDR(FILE_ADDR),
    .DEST_IS_FILE(DEST_IS_FILE), .BASE_SOURCE_REG(BASE_SRC), .SECOND_SOURCE_REG(SEC_SRC),
    .SRC_MODE(SRC_MODE), .DEST_REG(DEST_REG), .DST_MODE(DST_MODE), .UNSIGNED_TEN_BIT_LITERAL(ULIT),
    .SIGNED_TEN_BIT_LITERAL(SLIT), .BIT_POSITION_SELECT(BIT_SEL), .ACC_SEL(ACC_SEL),
    .ACCUMULATOR_WRITEBACK_TARGET(WB_TGT), .WB_POST_INC(WB_POST_INC), .MUL_X(MUL_X), .MUL_Y(MUL_Y),
    .PROGRAM_ADDRESS_LITERAL(PA_LIT), .FLAG_WE(FLAG_WE), .FLAG_IN(FLAG_IN), .STATUS_FLAGS(STATUS_FLAGS));

  dif_prog_mem_model dif_prog_mem_model_i (
    .clk(CLK), .resetn(RESETN), .slow(slow), .word_ready(IWORD_READY), .word_valid(IWORD_VALID),
    .word(IWORD), .cond_true(COND_TRUE), .empty(mem_empty));

  ////////////////////////////////////////////////////////////////////////////////
  // 40 MHz clock
  initial begin
    CLK = 1'b0;
    forever #12.5 CLK = ~CLK;
  end

  // Flag writes offered in every cycle; idle and no-op cycles see the inverse so a leak shows
  assign FLAG_IN = (EXEC_VALID === 1'b1) ? fl_good : ~fl_good;

  // Count executed and no-op pulses, each stands for one cycle
  always @(posedge CLK) begin
    if (EXEC_VALID === 1'b1) n_v++;
    if (EXEC_NOP === 1'b1) n_n++;
  end

  ////////////////////////////////////////////////////////////////////////////////
  task automatic end_of_test();
    if (n_errors == 0 && n_compared > 0) $display("Test passed");
    else $display("Test failed");
    $finish;
  endtask

  task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string what);
    n_compared++;
    if (got !== exp) begin
      n_errors++;
      $display("CHECK FAILED at %0t: %s got %0h expected %0h", $time, what, got, exp);
    end
  endtask

  // One APB transfer; the request holds until PREADY is seen high at an edge
  task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d, output logic [31:0] q,
                     output logic e);
    @(posedge CLK);
    PSEL <= 1'b1;
    PENABLE <= 1'b0;
    PWRITE <= wr;
    PADDR <= a;
    PWDATA <= d;
    @(posedge CLK);
    PENABLE <= 1'b1;
    @(posedge CLK);
    while (PREADY !== 1'b1) @(posedge CLK);
    q = PRDATA;
    e = PSLVERR;
    PSEL <= 1'b0;
    PENABLE <= 1'b0;
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    logic [31:0] q;
    logic e;
    apb(1'b0, a, 32'h00000000, q, e);
    chk(q, exp, "register read");
    chk({31'h0, e}, {31'h0, (a > REG_ERR)}, "slave error");
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    logic [31:0] q;
    logic e;
    apb(1'b1, a, d, q, e);
  endtask

  task automatic issue(input logic [23:0] w, input logic c);
    dif_prog_mem_model_i.push(w, c);
  endtask

  // Let the queued words drain, then compare executed and no-op counts
  task automatic settle(input int ev, input int en);
    int k;
    k = 0;
    repeat (2) @(posedge CLK);
    while (mem_empty !== 1'b1 && k < 100) begin
      @(posedge CLK);
      k++;
    end
    chk({31'h0, mem_empty}, 32'h1, "program memory drained");
    repeat (5) @(posedge CLK);
    chk(n_v, ev, "executed count");
    chk(n_n, en, "no-op count");
    n_v = 0;
    n_n = 0;
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Reset values, unmapped access, words held back until enabled, then a W-class word
  task automatic t_enable();
    rd(REG_CTRL, 32'h0);
    rd(REG_DECODE, 32'h0);
    rd(REG_ERR, 32'h0);
    rd(12'h010, 32'h0);
    issue(24'h45A953, 1'b0);
    repeat (6) @(posedge CLK);
    chk({IWORD_READY, n_v[3:0]}, 5'h00, "accept while disabled");
    rd(REG_FLAGS, 32'h0);
    wr(REG_CTRL, 32'h1);
    settle(1, 0);
    chk({OPCODE, BYTE_MODE}, {8'h45, 1'b1}, "opcode field");
    chk({BASE_SRC, DST_MODE, DEST_REG, SRC_MODE, SEC_SRC}, 16'hA953, "w operands");
  endtask

  // File, literal, bit and accumulator operand fields with their boundary values
  task automatic t_operands();
    logic [7:0] xy [6];
    xy = '{8'h45, 8'h46, 8'h47, 8'h56, 8'h57, 8'h67};
    issue(24'h809FFF, 1'b0);
    settle(1, 0);
    chk({FILE_ADDR, DEST_IS_FILE, BYTE_MODE}, {13'h1FFF, 2'b10}, "file top");
    issue(24'h810000, 1'b0);
    settle(1, 0);
    chk({FILE_ADDR, DEST_IS_FILE, BYTE_MODE}, {13'h0000, 2'b01}, "file to W0");
    issue(24'h903FF1, 1'b0);
    settle(1, 0);
    chk({ULIT, DEST_REG}, {10'h3FF, 4'h1}, "word literal");
    issue(24'h910FF0, 1'b0);
    settle(1, 0);
    chk(ULIT, 32'h0FF, "byte literal");
    issue(24'h911000, 1'b0);
    settle(0, 1);
    rd(REG_ERR, 32'h4);
    wr(REG_ERR, 32'h4);
    rd(REG_ERR, 32'h0);
    issue(24'h906000, 1'b0);
    settle(1, 0);
    chk({22'h0, SLIT}, 32'h200, "signed low");
    issue(24'h905FF0, 1'b0);
    settle(1, 0);
    chk({22'h0, SLIT}, 32'h1FF, "signed high");
    issue(24'hA0F000, 1'b0);
    settle(1, 0);
    chk(BIT_SEL, 32'hF, "bit select");
    for (int p = 0; p < 6; p++) begin
      issue({8'hC0, 2'b11, p[2:0], 11'h000}, 1'b0);
      settle(1, 0);
      chk({MUL_X, MUL_Y}, xy[p], "multiplier pair");
      chk({ACC_SEL, WB_TGT, WB_POST_INC}, 4'hE, "acc B to memory");
    end
    issue(24'hC00000, 1'b0);
    settle(1, 0);
    chk({ACC_SEL, WB_TGT, WB_POST_INC}, 4'h0, "acc A to W13");
    issue(24'hC03000, 1'b0);
    settle(0, 1);
    rd(REG_ERR, 32'h2);
  endtask

  // Cycle cost of each special kind, alone and back to back
  task automatic t_timing();
    logic [7:0] op [9];
    int nn [9];
    logic cd [9];
    op = '{8'h37, 8'h01, 8'hD0, 8'hF8, 8'h06, 8'h07, 8'h30, 8'h30, 8'h40};
    nn = '{1, 1, 1, 1, 2, 2, 1, 0, 0};
    cd = '{0, 0, 0, 0, 0, 0, 1, 0, 0};
    for (int i = 0; i < 9; i++) begin
      issue({op[i], 16'h0000}, cd[i]);
      settle(1, nn[i]);
    end
    issue(24'h400000, 1'b0);
    issue(24'h370000, 1'b0);
    issue(24'h060000, 1'b0);
    settle(3, 3);
    rd(REG_DECODE, 32'h406);
  endtask

  // Taken skips over one- and two-word instructions, with a slow program memory
  task automatic t_skip();
    slow <= 1'b1;
    issue(24'hE00000, 1'b1);
    issue(24'h400000, 1'b0);
    settle(1, 1);
    issue(24'hE00000, 1'b1);
    issue(24'h04BCDE, 1'b0);
    issue(24'h00002A, 1'b0);
    settle(1, 2);
    issue(24'hE00000, 1'b0);
    issue(24'h400000, 1'b0);
    settle(2, 0);
    slow <= 1'b0;
  endtask

  // Two-word instructions, a bad second word and an orphaned second word
  task automatic t_two_word();
    logic [7:0] op [3];
    op = '{8'h02, 8'h04, 8'h08};
    for (int i = 0; i < 3; i++) begin
      issue({op[i], 16'hBCDF}, 1'b0);
      issue(24'h00002A, 1'b0);
      settle(1, 0);
      chk(PA_LIT, 32'h2ABCDE, "program address");
    end
    issue(24'h02BCDE, 1'b0);
    issue(24'h01002A, 1'b0);
    settle(0, 1);
    rd(REG_ERR, 32'h3);
    wr(REG_ERR, 32'h7);
    rd(REG_ERR, 32'h0);
    issue(24'h00002A, 1'b0);
    settle(0, 1);
  endtask

  // Flags follow executed cycles only, never the inserted idle ones
  task automatic t_flags();
    chk(STATUS_FLAGS, 32'h1A5, "flags after run");
    fl_good <= 9'h05A;
    issue(24'h060000, 1'b0);
    settle(1, 2);
    chk(STATUS_FLAGS, 32'h05A, "flags after return");
    rd(REG_FLAGS, 32'h05A);
  endtask

  ////////////////////////////////////////////////////////////////////////////////
  // Main sequence
  initial begin
    RESETN = 1'b0;
    PSEL = 1'b0;
    PENABLE = 1'b0;
    PWRITE = 1'b0;
    PADDR = 12'h000;
    PWDATA = 32'h00000000;
    slow = 1'b0;
    FLAG_WE = 9'h000;
    fl_good = 9'h1A5;
    repeat (8) @(posedge CLK);
    RESETN <= 1'b1;
    FLAG_WE <= 9'h1FF;
    t_enable();
    t_operands();
    t_timing();
    t_skip();
    t_two_word();
    t_flags();
    end_of_test();
  end

  // Watchdog, far beyond the few hundred cycles the run needs
  initial begin
    repeat (20000) @(posedge CLK);
    n_errors++;
    end_of_test();
  end
endmodule // test_dsc_instruction_format_timing
